// file: hw/pmr_regs.sv
// Result, calibration and alert selection registers of the power monitor
`timescale 1ns/1ps
`default_nettype none
`include "pmr_cfg.svh"

// How it works
// - Bus result takes latest finished bus conversion
// - Results show averaged value when averaging on
// - Bus code step 1.25 mV, 7fff full scale
// - Bus result top bit always reads zero
// - Power step is 25 current steps
// - Power equals current code magnitude times bus code / 20000
// - Current equals shunt code times calibration / 2048
// - Written calibration applies to later calculations
// - Result registers ignore host writes
// - Mask register selects alert source and options
// - Highest enabled limit bit alone is compared
// - Ready flag sets at end, clears on mask read or non-powerdown config
// - Latch holds alert until mask register read
// - Polarity bit: clear active low, set active high
module pmr_regs
    import pmr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire pmr_req_type req,
    output logic [15:0] rdata,
    input wire pmr_sample_type sample,
    input wire logic [2:0] avg_sel,
    input wire logic [15:0] alert_limit,
    input wire logic cfg_write,
    input wire logic cfg_powerdown,
    output logic alert_o,
    output logic alert_oe
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync;
    logic rst_n;

    // Two flops release the asynchronous reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ****************************************
    // Register decode
    // ****************************************
    wire wr_cal = req.wr && (req.addr == `PMR_ADDR_CAL);
    wire wr_mask = req.wr && (req.addr == `PMR_ADDR_MASK);
    wire rd_mask = req.rd && (req.addr == `PMR_ADDR_MASK);

    logic [15:0] bus_rail_voltage;
    logic [15:0] power_result;
    logic [15:0] current_result;
    logic [14:0] shunt_calibration;
    logic [5:0] mask_ctrl;
    logic alert_function_flag;
    logic conv_done_flag;
    logic math_overflow_flag;
    logic alert_polarity;
    logic alert_latch_en;

    wire [15:0] mask_view = {mask_ctrl, 5'h00, alert_function_flag, conv_done_flag,
                             math_overflow_flag, alert_polarity, alert_latch_en};
    // Read mux; results have no write path at all
    wire [15:0] read_mux = (req.addr == `PMR_ADDR_BUS) ? bus_rail_voltage :
                           (req.addr == `PMR_ADDR_POWER) ? power_result :
                           (req.addr == `PMR_ADDR_CURRENT) ? current_result :
                           (req.addr == `PMR_ADDR_CAL) ? {1'b0, shunt_calibration} :
                           (req.addr == `PMR_ADDR_MASK) ? mask_view : 16'h0000;

    // Read data captured on the read strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 16'h0000;
        else if (req.rd)
            rdata <= read_mux;
    end

    // Host writable calibration and mask controls
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shunt_calibration <= `PMR_CAL_RESET;
            mask_ctrl <= `PMR_MASK_CTRL_RESET;
            alert_polarity <= 1'b0;
            alert_latch_en <= 1'b0;
        end
        else
        begin
            if (wr_cal)
                shunt_calibration <= req.wdata[14:0];
            if (wr_mask)
            begin
                mask_ctrl <= req.wdata[15:10];
                alert_polarity <= req.wdata[`PMR_PIN_SENSE_BIT];
                alert_latch_en <= req.wdata[`PMR_HOLD_EN_BIT];
            end
        end
    end

    // ****************************************
    // Averaging
    // ****************************************
    logic signed [25:0] acc_shunt;
    logic [25:0] acc_bus;
    logic [10:0] avg_count;
    logic [3:0] avg_shift;
    logic signed [15:0] avg_shunt;
    logic [15:0] avg_bus;
    logic avg_done;

    // Sample count per setting: 1,4,16,64,128,256,512,1024
    assign avg_shift = (avg_sel == 3'h0) ? 4'h0 :
                       (avg_sel == 3'h1) ? 4'h2 :
                       (avg_sel == 3'h2) ? 4'h4 :
                       (avg_sel == 3'h3) ? 4'h6 : 4'({1'b0, avg_sel} + 4'h3);

    wire signed [25:0] next_acc_shunt = acc_shunt + 26'($signed(sample.shunt));
    wire [25:0] next_acc_bus = acc_bus + {10'h000, sample.bus};
    wire [10:0] next_avg_count = avg_count + 11'h001;
    wire group_end = sample.valid && (next_avg_count == (11'h001 << avg_shift));

    // Accumulate until the group is full, then present the mean
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_shunt <= 26'sh0;
            acc_bus <= 26'h0;
            avg_count <= 11'h000;
            avg_shunt <= 16'sh0;
            avg_bus <= 16'h0;
            avg_done <= 1'b0;
        end
        else
        begin
            avg_done <= group_end;
            if (group_end)
            begin
                avg_shunt <= 16'(next_acc_shunt >>> avg_shift);
                avg_bus <= 16'(next_acc_bus >> avg_shift);
                acc_shunt <= 26'sh0;
                acc_bus <= 26'h0;
                avg_count <= 11'h000;
            end
            else if (sample.valid)
            begin
                acc_shunt <= next_acc_shunt;
                acc_bus <= next_acc_bus;
                avg_count <= next_avg_count;
            end
        end
    end

    // ****************************************
    // Current and power arithmetic
    // ****************************************
    logic [15:0] cur_val;
    logic [15:0] pwr_val;
    logic cur_ovf;
    logic pwr_ovf;
    logic signed [16:0] cur_abs;
    pmr_state_type state;
    pmr_state_type next_state;

    assign cur_abs = current_result[15] ? -$signed({current_result[15], current_result})
                                        : $signed({1'b0, current_result});

    // Current = shunt x calibration / 2048
    pmr_mul #(.DIV(`PMR_CURRENT_DIV), .SIGNED_OUT(1'b1)) u_cur (
        .a({avg_shunt[15], avg_shunt}),
        .b({1'b0, shunt_calibration}),
        .result(cur_val),
        .ovf(cur_ovf)
    );

    // Power = current x bus / 20000, giving a step 25 current steps wide
    pmr_mul #(.DIV(`PMR_POWER_DIV), .SIGNED_OUT(1'b0)) u_pwr (
        .a(cur_abs),
        .b(bus_rail_voltage),
        .result(pwr_val),
        .ovf(pwr_ovf)
    );

    // Sequencer: idle, current, power
    always_comb
    begin
        next_state = state;
        case (state)
            PMR_IDLE: if (avg_done) next_state = PMR_CUR;
            PMR_CUR: next_state = PMR_PWR;
            PMR_PWR: next_state = PMR_IDLE;
            default: next_state = PMR_IDLE;
        endcase
    end

    wire calc_done = (state == PMR_PWR);

    // Results load in sequence; bus top bit forced low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= PMR_IDLE;
            bus_rail_voltage <= `PMR_RESULT_RESET;
            current_result <= `PMR_RESULT_RESET;
            power_result <= `PMR_RESULT_RESET;
        end
        else
        begin
            state <= next_state;
            if (state == PMR_IDLE && avg_done)
                bus_rail_voltage <= {1'b0, avg_bus[14:0]};
            if (state == PMR_CUR)
                current_result <= cur_val;
            if (state == PMR_PWR)
                power_result <= pwr_val;
        end
    end

    // ****************************************
    // Alert selection and flags
    // ****************************************
    wire [4:0] limit_en = mask_ctrl[5:1];
    wire signed [15:0] shunt_s = avg_shunt;
    wire signed [15:0] limit_s = alert_limit;
    // Highest enabled limit function wins
    wire fault = limit_en[4] ? (shunt_s > limit_s) :
                 limit_en[3] ? (shunt_s < limit_s) :
                 limit_en[2] ? (bus_rail_voltage > alert_limit) :
                 limit_en[1] ? (bus_rail_voltage < alert_limit) :
                 limit_en[0] ? (pwr_val > alert_limit) : 1'b0;
    wire conv_done_alert_en = mask_ctrl[0];
    wire cfg_clear = cfg_write && !cfg_powerdown;

    // Flags: hardware set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alert_function_flag <= 1'b0;
            conv_done_flag <= 1'b0;
            math_overflow_flag <= 1'b0;
        end
        else
        begin
            if (calc_done)
                conv_done_flag <= 1'b1;
            else if (rd_mask || cfg_clear)
                conv_done_flag <= 1'b0;
            if (state == PMR_CUR)
                math_overflow_flag <= cur_ovf;
            else if (calc_done)
                math_overflow_flag <= math_overflow_flag | pwr_ovf;
            if (calc_done && fault)
                alert_function_flag <= 1'b1;
            else if (alert_latch_en ? rd_mask : calc_done)
                alert_function_flag <= 1'b0;
        end
    end

    // Open-collector alert: only ever pulls low
    wire alert_active = alert_function_flag || (conv_done_alert_en && conv_done_flag);
    assign alert_o = 1'b0;
    assign alert_oe = alert_polarity ? !alert_active : alert_active;

    // ****************************************
    // Checks
    // ****************************************
    property p_bus_top_zero;
        @(posedge clk) disable iff (!rst_n) bus_rail_voltage[15] == 1'b0;
    endproperty
    a_bus_top_zero: assert property (p_bus_top_zero) else $error("bus top bit set");

    property p_bus_load;
        @(posedge clk) disable iff (!rst_n)
            (state == PMR_IDLE && avg_done) |=> bus_rail_voltage == {1'b0, $past(avg_bus[14:0])};
    endproperty
    a_bus_load: assert property (p_bus_load) else $error("bus result not loaded");

    property p_ro_results;
        @(posedge clk) disable iff (!rst_n)
            (req.wr && state == PMR_IDLE && !avg_done) |=> $stable(current_result) && $stable(power_result) && $stable(bus_rail_voltage);
    endproperty
    a_ro_results: assert property (p_ro_results) else $error("result changed by write");

    property p_cal_write;
        @(posedge clk) disable iff (!rst_n)
            wr_cal |=> shunt_calibration == $past(req.wdata[14:0]);
    endproperty
    a_cal_write: assert property (p_cal_write) else $error("calibration not stored");

    property p_ready_sets;
        @(posedge clk) disable iff (!rst_n)
            (state == PMR_IDLE && avg_done) |-> ##2 calc_done ##1 conv_done_flag;
    endproperty
    a_ready_sets: assert property (p_ready_sets) else $error("ready flag late");

    property p_ready_clears;
        @(posedge clk) disable iff (!rst_n)
            (rd_mask && !calc_done) |=> !conv_done_flag;
    endproperty
    a_ready_clears: assert property (p_ready_clears) else $error("ready flag not cleared");

    property p_latch_holds;
        @(posedge clk) disable iff (!rst_n)
            (alert_latch_en && alert_function_flag && !rd_mask && !wr_mask) |=> alert_function_flag;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latched alert dropped");

    property p_polarity;
        @(posedge clk) disable iff (!rst_n)
            alert_oe == (alert_active ^ alert_polarity);
    endproperty
    a_polarity: assert property (p_polarity) else $error("alert pin polarity wrong");

    property p_priority;
        @(posedge clk) disable iff (!rst_n)
            (calc_done && limit_en[4] && shunt_s > limit_s) |=> alert_function_flag;
    endproperty
    a_priority: assert property (p_priority) else $error("top function ignored");

    property p_conv_done_alert_en_alert;
        @(posedge clk) disable iff (!rst_n)
            (conv_done_alert_en && conv_done_flag) |-> (alert_oe != alert_polarity);
    endproperty
    a_conv_done_alert_en_alert: assert property (p_conv_done_alert_en_alert) else $error("ready alert missing");

endmodule : pmr_regs
`default_nettype wire

// file: hw/pmr_cfg.svh
// Register offsets, field positions, reset values and scaling constants
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define PMR_ADDR_BUS 8'h02
`define PMR_ADDR_POWER 8'h03
`define PMR_ADDR_CURRENT 8'h04
`define PMR_ADDR_CAL 8'h05
`define PMR_ADDR_MASK 8'h06

// ****************************************
// Mask/enable field positions
// ****************************************
`define PMR_SHUNT_OVER_BIT 15
`define PMR_SHUNT_UNDER_BIT 14
`define PMR_RAIL_OVER_BIT 13
`define PMR_RAIL_UNDER_BIT 12
`define PMR_WATT_OVER_BIT 11
`define PMR_READY_EN_BIT 10
`define PMR_FUNC_FLAG_BIT 4
`define PMR_READY_FLAG_BIT 3
`define PMR_MATH_FLAG_BIT 2
`define PMR_PIN_SENSE_BIT 1
`define PMR_HOLD_EN_BIT 0

// ****************************************
// Reset values and scaling
// ****************************************
`define PMR_RESULT_RESET 16'h0000
`define PMR_CAL_RESET 15'h0000
`define PMR_MASK_CTRL_RESET 6'h00
`define PMR_CAL_MASK 16'h7fff
`define PMR_BUS_LSB_UV 1250
`define PMR_BUS_FULL_SCALE 16'h7fff
`define PMR_CURRENT_DIV 2048
`define PMR_POWER_DIV 20000
`define PMR_POWER_TO_CURRENT_LSB 25

`endif

// file: hw/pmr_pkg.sv
// Types shared by the power monitor result and alert register bank
package pmr_pkg;

    // Decoded register access from the serial interface
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } pmr_req_type;

    // One completed conversion pair from the converter
    typedef struct packed {
        logic valid;
        logic [15:0] shunt;
        logic [15:0] bus;
    } pmr_sample_type;

    // Arithmetic sequencer states
    typedef enum logic [2:0] {
        PMR_IDLE = 3'b001,
        PMR_CUR = 3'b010,
        PMR_PWR = 3'b100
    } pmr_state_type;

endpackage : pmr_pkg

// file: hw/pmr_mul.sv
// Scaled multiply with saturation and overflow detect
`timescale 1ns/1ps
`default_nettype none

module pmr_mul #(
    parameter int DIV = 2048,
    parameter bit SIGNED_OUT = 1'b1
) (
    input wire logic signed [16:0] a,
    input wire logic [15:0] b,
    output logic [15:0] result,
    output logic ovf
);
    localparam logic signed [33:0] HI = SIGNED_OUT ? 34'sh0_0000_7fff : 34'sh0_0000_ffff;
    localparam logic signed [33:0] LO = SIGNED_OUT ? -34'sh0_0000_8000 : 34'sh0_0000_0000;
    localparam logic signed [33:0] DIVISOR = 34'(DIV);

    logic signed [33:0] prod;
    logic signed [33:0] quot;

    // Product, then constant divide; saturate on overflow
    assign prod = a * $signed({1'b0, b});
    assign quot = prod / DIVISOR;
    assign ovf = (quot > HI) || (quot < LO);
    assign result = ovf ? ((quot < LO) ? LO[15:0] : HI[15:0]) : quot[15:0];

endmodule : pmr_mul
`default_nettype wire

// file: sim/pmr_host.sv
// Host model that reaches the register port in place of the serial controller
`timescale 1ns/1ps
`default_nettype none

module pmr_host
    import pmr_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] rdata,
    output var pmr_req_type req
);
    // ****************************************
    // Register access tasks
    // ****************************************
    initial req = '0;

    // One write strobe; data is scrambled once the strobe drops
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
        req.wdata = ~d;
    endtask : wr_reg

    // One read strobe; data is taken as the strobe drops
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        req.rd = 1'b0;
        d = rdata;
    endtask : rd_reg
endmodule : pmr_host

`default_nettype wire

// file: sim/power_monitor_result_alert_regs_tb.sv
// Self-checking bench for the power monitor result and alert registers
`timescale 1ns/1ps
`default_nettype none
`include "pmr_cfg.svh"

module power_monitor_result_alert_regs_tb
    import pmr_pkg::*;
;
    logic clk;
    logic nrst;
    pmr_req_type req;
    logic [15:0] rdata;
    pmr_sample_type sample;
    logic [2:0] avg_sel;
    logic [15:0] alert_limit;
    logic cfg_write;
    logic cfg_powerdown;
    logic alert_oe;
    logic alert_o;
    int bad_count = 0;
    int num_checks = 0;
    logic [14:0] cal;
    logic [15:0] e_bus, e_cur, e_pwr, d, sh, bv, lim, v;
    logic [4:0] en;
    logic fault;
    int ss, sb;

    // ****************************************
    // Design, host model and clock
    // ****************************************
    pmr_regs i_pmr_regs (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .sample(sample),
        .avg_sel(avg_sel), .alert_limit(alert_limit), .cfg_write(cfg_write),
        .cfg_powerdown(cfg_powerdown), .alert_o(alert_o), .alert_oe(alert_oe));
    pmr_host i_pmr_host (.clk(clk), .rdata(rdata), .req(req));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // Current code: shunt times calibration, scaled, truncated, saturated
    function automatic logic [15:0] exp_cur(input logic [15:0] s, input logic [14:0] c);
        longint p;
        p = longint'($signed(s)) * longint'(c) / `PMR_CURRENT_DIV;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        return p[15:0];
    endfunction : exp_cur

    // Power code: magnitude of current times bus, scaled, saturated
    function automatic logic [15:0] exp_pwr(input logic [15:0] c, input logic [15:0] b);
        longint p;
        p = longint'($signed(c));
        if (p < 0) p = -p;
        p = p * longint'(b) / `PMR_POWER_DIV;
        if (p > 65535) p = 65535;
        return p[15:0];
    endfunction : exp_pwr

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        i_pmr_host.rd_reg(a, d);
        check(d, e);
    endtask : rd_chk

    // One raw conversion pair; lines scrambled after the pulse
    task automatic send(input logic [15:0] s, input logic [15:0] b);
        @(negedge clk);
        sample = '{valid: 1'b1, shunt: s, bus: b};
        @(negedge clk);
        sample = '{valid: 1'b0, shunt: ~s, bus: ~b};
    endtask : send

    // Single-sample conversion with its expected results
    task automatic conv(input logic [15:0] s, input logic [15:0] b);
        e_bus = {1'b0, b[14:0]};
        e_cur = exp_cur(s, cal);
        e_pwr = exp_pwr(e_cur, e_bus);
        send(s, b);
        repeat (6) @(negedge clk);
    endtask : conv

    task automatic cfg(input logic pd);
        @(negedge clk);
        cfg_write = 1'b1;
        cfg_powerdown = pd;
        @(negedge clk);
        cfg_write = 1'b0;
    endtask : cfg

    // ****************************************
    // Watchdog
    // ****************************************
    initial
    begin
        #400000;
        bad_count++;
        summarize();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        nrst = 1'b0;
        sample = '0;
        avg_sel = 3'h0;
        alert_limit = 16'h0000;
        cfg_write = 1'b0;
        cfg_powerdown = 1'b0;
        cal = 15'h0000;
        void'($urandom(32'h0998));
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        // Reset values, unmapped addresses read zero
        check({15'h0000, alert_oe}, 16'h0000);
        check({15'h0000, alert_o}, 16'h0000);
        for (int a = 1; a < 8; a++)
            rd_chk(8'(a), 16'h0000);
        // Access kinds of calibration and mask
        i_pmr_host.wr_reg(`PMR_ADDR_CAL, 16'hffff);
        rd_chk(`PMR_ADDR_CAL, 16'h7fff);
        i_pmr_host.wr_reg(`PMR_ADDR_MASK, 16'hffff);
        rd_chk(`PMR_ADDR_MASK, 16'hfc03);
        check({15'h0000, alert_oe}, 16'h0001);
        // Random conversions with random alert selection near the limit
        for (int i = 0; i < 10; i++)
        begin
            cal = (i == 0) ? 15'h1fff : 15'($urandom_range(0, 8191));
            sh = (i == 0) ? 16'hf000 : 16'($urandom_range(0, 8191)) - 16'h1000;
            bv = (i == 0) ? 16'hffff : 16'($urandom);
            en = 5'($urandom_range(1, 31));
            i_pmr_host.wr_reg(`PMR_ADDR_CAL, {1'b0, cal});
            i_pmr_host.wr_reg(`PMR_ADDR_MASK, {en, 11'h000});
            e_bus = {1'b0, bv[14:0]};
            e_cur = exp_cur(sh, cal);
            e_pwr = exp_pwr(e_cur, e_bus);
            v = (en[4] | en[3]) ? sh : ((en[2] | en[1]) ? e_bus : e_pwr);
            lim = v + 16'($urandom_range(0, 4)) - 16'h0002;
            casez (en)
                5'b1????: fault = $signed(sh) > $signed(lim);
                5'b01???: fault = $signed(sh) < $signed(lim);
                5'b001??: fault = e_bus > lim;
                5'b0001?: fault = e_bus < lim;
                default: fault = e_pwr > lim;
            endcase
            alert_limit = lim;
            conv(sh, bv);
            check({15'h0000, alert_oe}, {15'h0000, fault});
            rd_chk(`PMR_ADDR_BUS, e_bus);
            rd_chk(`PMR_ADDR_CURRENT, e_cur);
            rd_chk(`PMR_ADDR_POWER, e_pwr);
            rd_chk(`PMR_ADDR_MASK, {en, 6'h00, fault, 4'b1000});
            rd_chk(`PMR_ADDR_MASK, {en, 6'h00, fault, 4'b0000});
            for (int a = 2; a < 5; a++)
            begin
                v = (a == 2) ? e_bus : ((a == 3) ? e_pwr : e_cur);
                i_pmr_host.wr_reg(8'(a), ~v);
                rd_chk(8'(a), v);
            end
        end
        // Averaging over four samples
        i_pmr_host.wr_reg(`PMR_ADDR_MASK, 16'h0000);
        avg_sel = 3'h1;
        ss = 0;
        sb = 0;
        for (int k = 0; k < 4; k++)
        begin
            sh = 16'($urandom_range(0, 8191)) - 16'h1000;
            bv = {1'b0, 15'($urandom)};
            ss += int'($signed(sh));
            sb += int'(bv);
            send(sh, bv);
        end
        repeat (6) @(negedge clk);
        e_bus = 16'(sb >> 2);
        e_cur = exp_cur(16'(ss >>> 2), cal);
        rd_chk(`PMR_ADDR_BUS, e_bus);
        rd_chk(`PMR_ADDR_CURRENT, e_cur);
        rd_chk(`PMR_ADDR_POWER, exp_pwr(e_cur, e_bus));
        avg_sel = 3'h0;
        // Latched, inverted alert on bus over limit
        i_pmr_host.wr_reg(`PMR_ADDR_MASK, 16'h2003);
        alert_limit = 16'h0064;
        conv(16'h0000, 16'h00c8);
        check({15'h0000, alert_oe}, 16'h0000);
        conv(16'h0000, 16'h0032);
        check({15'h0000, alert_oe}, 16'h0000);
        rd_chk(`PMR_ADDR_MASK, 16'h201b);
        check({15'h0000, alert_oe}, 16'h0001);
        // Conversion ready alert and configuration writes
        i_pmr_host.wr_reg(`PMR_ADDR_MASK, 16'h0400);
        conv(16'h0000, 16'h0000);
        check({15'h0000, alert_oe}, 16'h0001);
        cfg(1'b1);
        rd_chk(`PMR_ADDR_MASK, 16'h0408);
        conv(16'h0000, 16'h0000);
        cfg(1'b0);
        rd_chk(`PMR_ADDR_MASK, 16'h0400);
        summarize();
    end
endmodule : power_monitor_result_alert_regs_tb

`default_nettype wire
